// ---- src/twmr_consts.svh ----
// constants for the two-wire master/slave receiver block
`ifndef TWMR_CONSTS_SVH
`define TWMR_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets on apb
// ----------------------------------------------------------------
`define TWMR_OFF_CTRL   12'h000
`define TWMR_OFF_STAT   12'h004
`define TWMR_OFF_DATA   12'h008
`define TWMR_OFF_ADDR   12'h00C
`define TWMR_OFF_SLEEP  12'h010
// ----------------------------------------------------------------
// control bit positions
// ----------------------------------------------------------------
`define TWMR_B_IE    0
`define TWMR_B_EN    2
`define TWMR_B_WC    3
`define TWMR_B_STO   4
`define TWMR_B_STA   5
`define TWMR_B_EA    6
`define TWMR_B_INT   7
// ----------------------------------------------------------------
// status codes, prescaler bits zero
// ----------------------------------------------------------------
`define TWMR_S_START   8'h08
`define TWMR_S_RSTART  8'h10
`define TWMR_S_ARBLOST 8'h38
`define TWMR_S_SLAR_AK 8'h40
`define TWMR_S_SLAR_NK 8'h48
`define TWMR_S_DAT_AK  8'h50
`define TWMR_S_DAT_NK  8'h58
`define TWMR_S_SLAW_AK 8'h60
`define TWMR_S_AL_SLAW 8'h68
`define TWMR_S_GC_AK   8'h70
`define TWMR_S_AL_GC   8'h78
`define TWMR_S_SR_DAK  8'h80
`define TWMR_S_SR_DNK  8'h88
`define TWMR_S_MT_MODE 8'h18
`define TWMR_S_ST_MODE 8'hA8
`define TWMR_S_IDLE    8'hF8
`define TWMR_GC_ADDR   7'h00
// ----------------------------------------------------------------
// timing: quarter bit period of generated scl
// ----------------------------------------------------------------
`define TWMR_CLK_NS    25
`define TWMR_QTR_NS    2500
`define TWMR_QTR_CYC   (`TWMR_QTR_NS / `TWMR_CLK_NS)
`define TWMR_ZERO8     8'h00
`endif

// ---- src/twmr_pkg.sv ----
// types for the two-wire master/slave receiver block
package twmr_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } twmr_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } twmr_apb_rsp_t;
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } twmr_pin_out_t;
endpackage

// ---- src/twmr_top.sv ----
// two-wire unit: master receive and slave receive engine with apb registers
`include "twmr_consts.svh"
// Function
// R1 - start sent, status 08, send read address
// R2 - repeated start status 10, any direction
// R3 - arbitration lost: status 38, release/restart
// R4 - read address acked: status 40
// R5 - read address nacked: status 48, start/stop
// R6 - byte acked: status 50, continue
// R7 - byte nacked: status 58, start/stop
// R8 - status codes valid with prescaler zero
// R9 - upper seven address bits, lsb general call
// R10 - software sets address, enable, ack bits
// R11 - wait for own/general address, direction
// R12 - own write address sets flag, status
// R13 - lost arbitration then addressed: 68/78
// R14 - ack enable cleared gives nack next byte
// R15 - ack enable zero ignores own address
// R16 - sleep: address match still acknowledged
// R17 - after wake hold scl until flag cleared
// R18 - data register undefined after wake
// R19 - address direction picks master mode
// R20 - master nacks last byte by software
// R21 - writing one clears interrupt flag
// R22 - stretch scl low while flag set; the engine leaves scl released for status A8 and for a 38 lost in the address
module twmr_top (
  // system
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // apb slave
  input  wire twmr_pkg::twmr_apb_req_t apb_req,
  output      twmr_pkg::twmr_apb_rsp_t apb_rsp,
  // bus pins
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output      twmr_pkg::twmr_pin_out_t pins,
  // power and interrupt
  output      logic                   wake_req,
  output      logic                   irq_level
);
  import twmr_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_FREE, ST_START, ST_HOLD, ST_TX_BIT, ST_RX_ACK,
    ST_RX_BIT, ST_TX_ACK, ST_STOP, ST_SL_ADDR, ST_SL_ACK, ST_SL_DATA, ST_SL_DACK
  } twmr_state_t;

  // ----------------------------------------------------------------
  // pin synchronisers, change counts once stages two and three agree
  // ----------------------------------------------------------------
  logic [2:0] scl_sync_ff, sda_sync_ff;
  logic       scl_ff, sda_ff, scl_q_ff, sda_q_ff;
  // three-stage capture
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
    end
  end
  // filtered levels and their previous values
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_ff   <= 1'b1;
      sda_ff   <= 1'b1;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      if (scl_sync_ff[1] == scl_sync_ff[2]) scl_ff <= scl_sync_ff[2];
      if (sda_sync_ff[1] == sda_sync_ff[2]) sda_ff <= sda_sync_ff[2];
      scl_q_ff <= scl_ff;
      sda_q_ff <= sda_ff;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_ff & ~scl_q_ff;
  assign scl_fall  = ~scl_ff & scl_q_ff;
  assign bus_start = scl_ff & scl_q_ff & sda_q_ff & ~sda_ff;
  assign bus_stop  = scl_ff & scl_q_ff & ~sda_q_ff & sda_ff;

  // ----------------------------------------------------------------
  // bus busy tracking
  // ----------------------------------------------------------------
  logic busy_ff;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) busy_ff <= 1'b0;
    else if (bus_start) busy_ff <= 1'b1;
    else if (bus_stop) busy_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_ff, stat_ff, data_ff, addr_ff;
  logic        sleep_ff;
  twmr_state_t state_ff;
  logic        set_int, clr_sto, ld_rx, wake_ff, is_master_ff;
  logic [7:0]  nxt_stat;
  logic [7:0]  shreg_ff;
  logic        wr_acc, rd_acc;
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

  // control: R21 write one clears flag, set wins over clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= `TWMR_ZERO8;
    end else begin
      if (wr_acc && apb_req.paddr == `TWMR_OFF_CTRL) begin
        ctrl_ff[6:0] <= apb_req.pwdata[6:0];
        ctrl_ff[`TWMR_B_WC] <= ctrl_ff[`TWMR_B_WC];
        ctrl_ff[1] <= 1'b0;
        if (apb_req.pwdata[`TWMR_B_INT]) ctrl_ff[`TWMR_B_INT] <= 1'b0;
      end else if (wr_acc && apb_req.paddr == `TWMR_OFF_DATA) begin
        // data write while the flag is clear flags a collision
        if (!ctrl_ff[`TWMR_B_INT]) ctrl_ff[`TWMR_B_WC] <= 1'b1;
      end
      // R5 stop request clears itself once stop goes out
      if (clr_sto) ctrl_ff[`TWMR_B_STO] <= 1'b0;
      if (set_int) ctrl_ff[`TWMR_B_INT] <= 1'b1;
    end
  end
  // R9 own address, lsb general call enable
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) addr_ff <= `TWMR_ZERO8;
    else if (wr_acc && apb_req.paddr == `TWMR_OFF_ADDR) addr_ff <= apb_req.pwdata[7:0];
  end
  // sleep request from the system
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) sleep_ff <= 1'b0;
    else if (wr_acc && apb_req.paddr == `TWMR_OFF_SLEEP) sleep_ff <= apb_req.pwdata[0];
    else if (wake_ff && set_int) sleep_ff <= 1'b0;
  end
  // data buffer; R18 received bytes during sleep are not stored
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) data_ff <= `TWMR_ZERO8;
    else if (wr_acc && apb_req.paddr == `TWMR_OFF_DATA && ctrl_ff[`TWMR_B_INT]) data_ff <= apb_req.pwdata[7:0];
    else if (ld_rx && !sleep_ff) data_ff <= shreg_ff;
  end
  // R8 status register, prescaler bits held at zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) stat_ff <= `TWMR_S_IDLE;
    else if (set_int) stat_ff <= nxt_stat;
    else if (wr_acc && apb_req.paddr == `TWMR_OFF_CTRL && apb_req.pwdata[`TWMR_B_INT]) stat_ff <= `TWMR_S_IDLE;
  end
  // read mux and answer: zero wait, unmapped reads zero with error
  always_comb begin
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = 1'b0;
    apb_rsp.prdata  = 32'h0000_0000;
    if (apb_req.paddr == `TWMR_OFF_CTRL) apb_rsp.prdata = {24'h000000, ctrl_ff};
    else if (apb_req.paddr == `TWMR_OFF_STAT) apb_rsp.prdata = {24'h000000, stat_ff};
    else if (apb_req.paddr == `TWMR_OFF_DATA) apb_rsp.prdata = {24'h000000, data_ff};
    else if (apb_req.paddr == `TWMR_OFF_ADDR) apb_rsp.prdata = {24'h000000, addr_ff};
    else if (apb_req.paddr == `TWMR_OFF_SLEEP) apb_rsp.prdata = {31'h0, sleep_ff};
    else apb_rsp.pslverr = apb_req.psel & apb_req.penable;
  end
  logic unused_rd;
  assign unused_rd = rd_acc;
  assign irq_level = ctrl_ff[`TWMR_B_INT] & ctrl_ff[`TWMR_B_IE];

  // ----------------------------------------------------------------
  // quarter-period tick for master timing
  // ----------------------------------------------------------------
  logic [7:0] div_ff;
  logic       tick;
  assign tick = (div_ff == 8'(`TWMR_QTR_CYC - 1));
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) div_ff <= `TWMR_ZERO8;
    else if (tick) div_ff <= `TWMR_ZERO8;
    else div_ff <= div_ff + 8'h01;
  end

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  logic [3:0] bit_ff;
  logic [1:0] ph_ff;
  logic       scl_lo_ff, sda_lo_ff, sent_start_ff, ack_ff, al_ff, rd_dir_ff;
  logic       int_now, en, gc_hit, own_hit;
  assign int_now = ctrl_ff[`TWMR_B_INT];
  assign en      = ctrl_ff[`TWMR_B_EN];
  assign own_hit = shreg_ff[7:1] == addr_ff[7:1];
  assign gc_hit  = addr_ff[0] && shreg_ff[7:1] == `TWMR_GC_ADDR;
  assign wake_req = wake_ff;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      bit_ff <= 4'h0;
      ph_ff <= 2'h0;
      scl_lo_ff <= 1'b0;
      sda_lo_ff <= 1'b0;
      shreg_ff <= `TWMR_ZERO8;
      sent_start_ff <= 1'b0;
      ack_ff <= 1'b0;
      al_ff <= 1'b0;
      rd_dir_ff <= 1'b0;
      wake_ff <= 1'b0;
      is_master_ff <= 1'b0;
      set_int <= 1'b0;
      clr_sto <= 1'b0;
      ld_rx <= 1'b0;
      nxt_stat <= `TWMR_S_IDLE;
    end else begin
      set_int <= 1'b0;
      clr_sto <= 1'b0;
      ld_rx <= 1'b0;
      if (!en) begin
        state_ff <= ST_IDLE;
        scl_lo_ff <= 1'b0;
        sda_lo_ff <= 1'b0;
        is_master_ff <= 1'b0;
      end else if (bus_start && !is_master_ff && state_ff != ST_HOLD && state_ff != ST_START) begin
        // our own start is heard back before is_master_ff rises, so it must not re-arm the slave side
        // R11 a start heard outside master mode, ST_HOLD and ST_START arms address reception
        state_ff <= ST_SL_ADDR;
        bit_ff <= 4'h0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            sda_lo_ff <= 1'b0;
            scl_lo_ff <= 1'b0;
            if (ctrl_ff[`TWMR_B_STA] && !int_now) state_ff <= ST_WAIT_FREE;
          end
          ST_WAIT_FREE: begin
            // R3 start issued only once the bus is free
            if (!busy_ff && tick) begin
              state_ff <= ST_START;
              ph_ff <= 2'h0;
            end
          end
          ST_START: if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h0) begin
              scl_lo_ff <= 1'b0;
              sda_lo_ff <= 1'b0;
            end else if (ph_ff == 2'h1) sda_lo_ff <= 1'b1;
            else if (ph_ff == 2'h2) begin
              scl_lo_ff <= 1'b1;
              is_master_ff <= 1'b1;
              // R1 R2 start or repeated start status
              nxt_stat <= sent_start_ff ? `TWMR_S_RSTART : `TWMR_S_START;
              sent_start_ff <= 1'b1;
              set_int <= 1'b1;
              state_ff <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            // R22 scl held low while the flag is up
            scl_lo_ff <= 1'b1;
            if (!int_now && !set_int) begin
              bit_ff <= 4'h0;
              ph_ff <= 2'h0;
              if (is_master_ff && ctrl_ff[`TWMR_B_STO]) state_ff <= ST_STOP;
              else if (is_master_ff && ctrl_ff[`TWMR_B_STA]) begin
                sda_lo_ff <= 1'b0;
                state_ff <= ST_START;
              // the status register already reads idle once the flag is cleared, so the held code decides
              end else if (is_master_ff && (nxt_stat == `TWMR_S_START || nxt_stat == `TWMR_S_RSTART)) begin
                shreg_ff <= data_ff;
                rd_dir_ff <= data_ff[0];
                state_ff <= ST_TX_BIT;
              end else if (is_master_ff) state_ff <= ST_RX_BIT;
              else if (nxt_stat == `TWMR_S_IDLE || nxt_stat == `TWMR_S_ARBLOST) begin
                scl_lo_ff <= 1'b0;
                state_ff <= ST_IDLE;
              end else begin
                scl_lo_ff <= 1'b0;
                wake_ff <= 1'b0;
                state_ff <= ST_SL_DATA;
              end
            end
          end
          ST_TX_BIT: if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h0) sda_lo_ff <= ~shreg_ff[7];
            else if (ph_ff == 2'h1) scl_lo_ff <= 1'b0;
            else if (ph_ff == 2'h2 && !sda_lo_ff && !sda_ff) begin
              // R3 arbitration lost in the address
              al_ff <= 1'b1;
              sda_lo_ff <= 1'b0;
              is_master_ff <= 1'b0;
              scl_lo_ff <= 1'b0;
              state_ff <= ST_SL_ADDR;
              bit_ff <= bit_ff + 4'h1;
              shreg_ff <= {shreg_ff[6:0], sda_ff};
            end else if (ph_ff == 2'h3) begin
              scl_lo_ff <= 1'b1;
              shreg_ff <= {shreg_ff[6:0], 1'b0};
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == 4'h7) state_ff <= ST_RX_ACK;
            end
          end
          ST_RX_ACK: if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h0) sda_lo_ff <= 1'b0;
            else if (ph_ff == 2'h1) scl_lo_ff <= 1'b0;
            else if (ph_ff == 2'h2) ack_ff <= ~sda_ff;
            else begin
              scl_lo_ff <= 1'b1;
              set_int <= 1'b1;
              state_ff <= ST_HOLD;
              // R19 write direction hands over to transmit mode
              if (!rd_dir_ff) nxt_stat <= `TWMR_S_MT_MODE;
              // R4 R5 address ack or nack
              else nxt_stat <= ack_ff ? `TWMR_S_SLAR_AK : `TWMR_S_SLAR_NK;
            end
          end
          ST_RX_BIT: if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h0) sda_lo_ff <= 1'b0;
            else if (ph_ff == 2'h1) scl_lo_ff <= 1'b0;
            else if (ph_ff == 2'h2) shreg_ff <= {shreg_ff[6:0], sda_ff};
            else begin
              scl_lo_ff <= 1'b1;
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == 4'h7) state_ff <= ST_TX_ACK;
            end
          end
          ST_TX_ACK: if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            // R14 ack enable picks ack or nack
            if (ph_ff == 2'h0) sda_lo_ff <= ctrl_ff[`TWMR_B_EA];
            else if (ph_ff == 2'h1) scl_lo_ff <= 1'b0;
            else if (ph_ff == 2'h2 && !sda_lo_ff && !sda_ff) begin
              // R3 arbitration lost in the nack bit
              is_master_ff <= 1'b0;
              scl_lo_ff <= 1'b0;
              nxt_stat <= `TWMR_S_ARBLOST;
              set_int <= 1'b1;
              ld_rx <= 1'b1;
              state_ff <= ST_HOLD;
            end else if (ph_ff == 2'h3) begin
              scl_lo_ff <= 1'b1;
              ld_rx <= 1'b1;
              set_int <= 1'b1;
              // R6 R7 data ack or nack status
              nxt_stat <= sda_lo_ff ? `TWMR_S_DAT_AK : `TWMR_S_DAT_NK;
              state_ff <= ST_HOLD;
            end
          end
          ST_STOP: if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h0) sda_lo_ff <= 1'b1;
            else if (ph_ff == 2'h1) scl_lo_ff <= 1'b0;
            else if (ph_ff == 2'h2) sda_lo_ff <= 1'b0;
            else begin
              // R5 R7 stop request self-clears; start follows if asked
              clr_sto <= 1'b1;
              is_master_ff <= 1'b0;
              sent_start_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
          ST_SL_ADDR: begin
            // R16 slave sampling runs off scl edges, also in sleep
            if (scl_rise) begin
              shreg_ff <= {shreg_ff[6:0], sda_ff};
              bit_ff <= bit_ff + 4'h1;
            end
            if (scl_fall && bit_ff == 4'h8) begin
              // R15 no address match while ack enable is zero
              if (ctrl_ff[`TWMR_B_EA] && (own_hit || gc_hit) && !shreg_ff[0]) begin
                sda_lo_ff <= 1'b1;
                state_ff <= ST_SL_ACK;
              end else if (ctrl_ff[`TWMR_B_EA] && own_hit) begin
                // R11 read direction: transmit side not built here
                nxt_stat <= `TWMR_S_ST_MODE;
                set_int <= 1'b1;
                state_ff <= ST_IDLE;
              end else begin
                if (al_ff) begin
                  nxt_stat <= `TWMR_S_ARBLOST;
                  set_int <= 1'b1;
                end
                al_ff <= 1'b0;
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_SL_ACK: if (scl_fall) begin
            sda_lo_ff <= 1'b0;
            scl_lo_ff <= 1'b1;
            wake_ff <= sleep_ff;
            set_int <= 1'b1;
            al_ff <= 1'b0;
            state_ff <= ST_HOLD;
            // R12 R13 own or general call, with lost arbitration
            if (own_hit) nxt_stat <= al_ff ? `TWMR_S_AL_SLAW : `TWMR_S_SLAW_AK;
            else nxt_stat <= al_ff ? `TWMR_S_AL_GC : `TWMR_S_GC_AK;
          end
          ST_SL_DATA: begin
            if (bus_stop) state_ff <= ST_IDLE;
            if (scl_rise) begin
              shreg_ff <= {shreg_ff[6:0], sda_ff};
              bit_ff <= bit_ff + 4'h1;
            end
            if (scl_fall && bit_ff == 4'h8) begin
              // R14 cleared ack enable returns nack
              sda_lo_ff <= ctrl_ff[`TWMR_B_EA];
              state_ff <= ST_SL_DACK;
            end
          end
          ST_SL_DACK: if (scl_fall) begin
            sda_lo_ff <= 1'b0;
            scl_lo_ff <= 1'b1;
            ld_rx <= 1'b1;
            set_int <= 1'b1;
            nxt_stat <= sda_lo_ff ? `TWMR_S_SR_DAK : `TWMR_S_SR_DNK;
            state_ff <= ST_HOLD;
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // R17 scl driven low on wake until flag cleared
  assign pins.scl_o  = 1'b0;
  assign pins.scl_oe = scl_lo_ff;
  assign pins.sda_o  = 1'b0;
  assign pins.sda_oe = sda_lo_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_scl_a: assert property (@(posedge clock) disable iff (sys_rst) // R22
    (state_ff == ST_HOLD && int_now) |-> pins.scl_oe) else $error("scl not stretched");
  clr_flag_a: assert property (@(posedge clock) disable iff (sys_rst) // R21
    (wr_acc && apb_req.paddr == `TWMR_OFF_CTRL && apb_req.pwdata[`TWMR_B_INT] && !set_int)
    |=> !ctrl_ff[`TWMR_B_INT]) else $error("flag not cleared");
  start_stat_a: assert property (@(posedge clock) disable iff (sys_rst) // R1
    (state_ff == ST_START && tick && ph_ff == 2'h2 && !sent_start_ff) |=> ##1 stat_ff == `TWMR_S_START)
    else $error("start status wrong");
  sto_clear_a: assert property (@(posedge clock) disable iff (sys_rst) // R5
    (state_ff == ST_STOP && tick && ph_ff == 2'h3) |=> ##1 !ctrl_ff[`TWMR_B_STO]) else $error("stop bit kept");
  nack_ea_a: assert property (@(posedge clock) disable iff (sys_rst) // R14
    (state_ff == ST_TX_ACK && tick && ph_ff == 2'h0) |=> (sda_lo_ff == $past(ctrl_ff[`TWMR_B_EA])))
    else $error("ack level wrong");
  no_match_a: assert property (@(posedge clock) disable iff (sys_rst) // R15
    (state_ff == ST_SL_ADDR && !ctrl_ff[`TWMR_B_EA]) |=> state_ff != ST_SL_ACK) else $error("acked with ea low");
  wake_hold_a: assert property (@(posedge clock) disable iff (sys_rst) // R17
    (wake_ff && int_now) |-> pins.scl_oe) else $error("scl released in wake");
  sl_stat_a: assert property (@(posedge clock) disable iff (sys_rst) // R12
    (state_ff == ST_SL_ACK && scl_fall) |=> set_int ##1 int_now) else $error("slave flag missing");
  dat_stat_a: assert property (@(posedge clock) disable iff (sys_rst) // R6
    (state_ff == ST_TX_ACK && tick && ph_ff == 2'h3 && sda_lo_ff) |=> ##1 stat_ff == `TWMR_S_DAT_AK)
    else $error("data ack status wrong");
  start_c: cover property (@(posedge clock) disable iff (sys_rst) stat_ff == `TWMR_S_START);
  mrx_c: cover property (@(posedge clock) disable iff (sys_rst) stat_ff == `TWMR_S_DAT_NK);
  srx_c: cover property (@(posedge clock) disable iff (sys_rst) stat_ff == `TWMR_S_SR_DAK);
endmodule

// ---- sim/twmr_part.sv ----
// remote slave transmitter model for the two-wire bus
module twmr_part #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter logic [7:0] TXB  = 8'hA5
) (
  // bus wires
  input  wire logic scl,
  input  wire logic sda,
  // open-drain pull of sda
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  int         n   = 0;
  logic [7:0] sh  = 8'h00;
  logic       adr = 1'b0;
  logic       rdm = 1'b0;
  logic       nak = 1'b0;
  initial sda_low = 1'b0;
  // start or stop: restart the frame, let go of sda
  always @(sda) if (scl === 1'b1) begin
    n = -1;
    adr = ~sda;
    rdm = 1'b0;
    sda_low = 1'b0;
  end
  // shift bits in on scl rise, ninth bit is the ack slot
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    if (n == 8) nak = sda;
  end
  // changes only while scl is low, so no false start or stop
  always @(negedge scl) begin
    n = n + 1;
    sda_low = 1'b0;
    if (adr && n == 8) begin
      rdm = sh[0] && (sh[7:1] == ADDR);
      sda_low = (sh[7:1] == ADDR);
    end
    if (n == 9) begin
      n = 0;
      adr = 1'b0;
      rdm = rdm && !nak;
    end
    // send bytes until the master nacks
    if (!adr && rdm && n < 8) sda_low = ~TXB[7-n];
  end
endmodule

// ---- sim/twmr_top_tb_top.sv ----
// testbench for the two-wire master/slave receiver block
`include "twmr_consts.svh"
module twmr_top_tb_top;
  import twmr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clock     = 1'b0;
  logic          sys_rst   = 1'b1;
  twmr_apb_req_t apb_req   = '0;
  twmr_apb_rsp_t apb_rsp;
  twmr_pin_out_t pins;
  logic          sda_low;
  logic          m_scl     = 1'b0;
  logic          m_sda     = 1'b0;
  logic          ak;
  logic          wake_req;
  logic          irq_level;
  logic [31:0]   rd;
  logic          err;
  int            error_cnt = 0;
  int            compares  = 0;
  // pull-ups: a line is low only while someone pulls it
  wire scl = ~(pins.scl_oe | m_scl);
  wire sda = ~(pins.sda_oe | sda_low | m_sda);
  always #12.5 clock = ~clock;
  twmr_top i_dut (.clock(clock), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .scl_i(scl), .sda_i(sda), .pins(pins), .wake_req(wake_req), .irq_level(irq_level));
  twmr_part i_part (.scl(scl), .sda(sda), .sda_low(sda_low));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  // poll a control bit; bounded so a stuck bus cannot hang here
  task automatic poll(input int b, input logic v);
    int k = 0;
    do begin
      apb(1'b0, `TWMR_OFF_CTRL, '0);
      k++;
    end while (rd[b] !== v && k < 3000);
  endtask
  task automatic wait_stat(input logic [7:0] code);
    poll(`TWMR_B_INT, 1'b1);
    apb(1'b0, `TWMR_OFF_STAT, '0);
    chk(rd, {24'h0, code});
  endtask
  // remote master: scl first, sda a cycle later, so no false start or stop; waits out stretching
  task automatic mdrv(input logic c, input logic d);
    @(posedge clock);
    m_scl <= ~c;
    @(posedge clock);
    m_sda <= ~d;
    do @(posedge clock); while (c && scl !== 1'b1);
    repeat (20) @(posedge clock);
  endtask
  // optional start, one byte, then the ack slot; ak is what the slave returned
  task automatic mbyte(input logic st, input logic [7:0] b);
    if (st) mdrv(1'b1, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      mdrv(1'b0, b[i]);
      mdrv(1'b1, b[i]);
    end
    mdrv(1'b0, 1'b1);
    mdrv(1'b1, 1'b1);
    ak = ~sda;
    mdrv(1'b0, 1'b1);
  endtask
  task automatic mstop();
    mdrv(1'b0, 1'b0);
    mdrv(1'b1, 1'b0);
    mdrv(1'b1, 1'b1);
  endtask
  task automatic t_slave();
    // slave set-up: address, enable, ack enable
    apb(1'b1, `TWMR_OFF_ADDR, 32'h64);
    apb(1'b1, `TWMR_OFF_CTRL, 32'h45);
    apb(1'b1, `TWMR_OFF_SLEEP, 32'h1);
    mbyte(1'b1, 8'h64);
    chk({31'h0, ak}, 32'h1);
    wait_stat(`TWMR_S_SLAW_AK);
    chk({30'h0, wake_req, pins.scl_oe}, 32'h3);
    chk({31'h0, irq_level}, 32'h1);
    apb(1'b1, `TWMR_OFF_CTRL, 32'hC5);
    mbyte(1'b0, 8'h3C);
    chk({31'h0, ak}, 32'h1);
    wait_stat(`TWMR_S_SR_DAK);
    chk({31'h0, wake_req}, 32'h0);
    apb(1'b0, `TWMR_OFF_DATA, '0);
    chk(rd, 32'h3C);
    apb(1'b1, `TWMR_OFF_CTRL, 32'h85);
    mbyte(1'b0, 8'hC3);
    chk({31'h0, ak}, 32'h0);
    wait_stat(`TWMR_S_SR_DNK);
    apb(1'b1, `TWMR_OFF_CTRL, 32'h85);
    mstop();
    mbyte(1'b1, 8'h64);
    chk({31'h0, ak}, 32'h0);
    mstop();
    $display("test slave done");
  endtask
  task automatic t_regs();
    apb(1'b0, `TWMR_OFF_CTRL, '0);
    chk(rd, 32'h0);
    apb(1'b0, `TWMR_OFF_STAT, '0);
    chk(rd, {24'h0, `TWMR_S_IDLE});
    apb(1'b1, `TWMR_OFF_ADDR, 32'hA5);
    apb(1'b0, `TWMR_OFF_ADDR, '0);
    chk(rd, 32'hA5);
    apb(1'b1, 12'h014, 32'hFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h014, '0);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_master();
    apb(1'b1, `TWMR_OFF_CTRL, 32'hA4);
    wait_stat(`TWMR_S_START);
    chk({31'h0, pins.scl_oe}, 32'h1);
    // wrong slave first: no ack expected
    apb(1'b1, `TWMR_OFF_DATA, 32'hA3);
    apb(1'b1, `TWMR_OFF_CTRL, 32'h84);
    wait_stat(`TWMR_S_SLAR_NK);
    apb(1'b1, `TWMR_OFF_CTRL, 32'hB4);
    wait_stat(`TWMR_S_START);
    apb(1'b1, `TWMR_OFF_DATA, 32'hA1);
    apb(1'b1, `TWMR_OFF_CTRL, 32'h84);
    wait_stat(`TWMR_S_SLAR_AK);
    apb(1'b1, `TWMR_OFF_CTRL, 32'hC4);
    wait_stat(`TWMR_S_DAT_AK);
    apb(1'b0, `TWMR_OFF_DATA, '0);
    chk(rd, 32'hA5);
    apb(1'b1, `TWMR_OFF_CTRL, 32'h84);
    wait_stat(`TWMR_S_DAT_NK);
    apb(1'b1, `TWMR_OFF_CTRL, 32'h94);
    poll(`TWMR_B_STO, 1'b0);
    chk(rd[`TWMR_B_STO], 1'b0);
    repeat (500) @(posedge clock);
    chk({30'h0, scl, sda}, 32'h3);
    // data write with the flag clear is refused
    apb(1'b1, `TWMR_OFF_DATA, 32'h11);
    apb(1'b0, `TWMR_OFF_CTRL, '0);
    chk(rd[`TWMR_B_WC], 1'b1);
    $display("test master done");
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_master();
    t_slave();
    tally_and_finish();
  end
  // watchdog: the whole run needs about 20000 cycles
  initial begin
    repeat (80000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
endmodule
